// [hw/audio_dac_control_registers.v]
// Control and status register bank of the eight-channel audio converter
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_regs.vh"

module audio_dac_control_registers
(
    // Clock, reset, enable
    input  wire                  clk_sys,
    input  wire                  rst,
    input  wire                  ce,
    // Control word port
    input  wire [15:0]           ctrl_word,
    input  wire                  ctrl_valid,
    output reg  [7:0]            ctrl_rdata_r,
    output reg                   ctrl_rvalid_r,
    // Register bus
    input  wire [`ADDR_W-1:0]    bus_addr,
    input  wire [7:0]            bus_wdata,
    input  wire                  bus_wr,
    input  wire                  bus_rd,
    output reg  [7:0]            bus_rdata_r,
    // Datapath status
    input  wire                  frame_sync_input,
    input  wire [7:0]            channel_sample_zero,
    input  wire [4:0]            chain_identifier,
    // Settings to the datapath
    output reg  [2:0]            audio_format_sel,
    output reg  [1:0]            modulator_rate_sel,
    output reg  [1:0]            deemph_rate_sel,
    output reg  [3:0]            pair_deemph_enable,
    output reg                   one_bit_stream_mode,
    output reg  [3:0]            pair_phase_invert,
    output reg  [15:0]           channel_stream_filter_sel,
    output reg                   soft_reset_pulse,
    // Zero flag pins and interrupt
    output reg                   first_channel_zero_pin,
    output reg                   second_channel_zero_pin,
    output reg                   upper_channels_zero_pin,
    output wire                  irq
);

    // Register file
    reg  [7:0] fmt_ctrl_r;
    reg  [7:0] ovr_deemph_r;
    reg  [6:0] mode_ctrl_r;
    reg  [7:0] fsel_lo_r;
    reg  [7:0] fsel_hi_r;
    reg  [3:0] irq_status_r;
    reg  [3:0] irq_mask_r;
    reg        soft_reset_pulse_pend_r;

    // Frame sync sampled through three stages
    reg  [2:0] sync_pipe_r;
    reg        sync_last_r;
    wire       sample_tick;
    wire [7:0] zero_det;
    reg  [7:0] zero_det_last_r;

    // Merged write from both ports, read strobe from the serial word only; the serial word wins a write collision
    wire       cw_wr;
    wire       cw_rd;
    wire       wr_en;
    wire       rd_en;
    wire [`ADDR_W-1:0] wr_addr;
    wire [7:0] wr_data;

    reg  [7:0] irq_set;
    reg        reserved_hit;

    function [7:0] read_reg;
        input [`ADDR_W-1:0] a;
        begin
            case (a)
                `OFS_FMT_CTRL:    read_reg = fmt_ctrl_r;
                `OFS_OVR_DEEMPH:  read_reg = ovr_deemph_r;
                // Soft reset bit is write-only and reads zero
                `OFS_MODE_CTRL:   read_reg = {1'b0, mode_ctrl_r};
                `OFS_FSEL_LO:     read_reg = fsel_lo_r;
                `OFS_FSEL_HI:     read_reg = fsel_hi_r;
                `OFS_ZERO_STATUS: read_reg = zero_det;
                `OFS_CHAIN_ID:    read_reg = {3'h0, chain_identifier};
                `OFS_IRQ_STATUS:  read_reg = {4'h0, irq_status_r};
                `OFS_IRQ_MASK:    read_reg = {4'h0, irq_mask_r};
                default:          read_reg = 8'h00;
            endcase
        end
    endfunction

    function has_reserved_fsel;
        input [7:0] v;
        begin
            has_reserved_fsel = (v[1:0] == 2'h3) || (v[3:2] == 2'h3) ||
                                (v[5:4] == 2'h3) || (v[7:6] == 2'h3);
        end
    endfunction

    assign cw_wr   = ctrl_valid && !ctrl_word[15];
    assign cw_rd   = ctrl_valid &&  ctrl_word[15];
    assign wr_en   = cw_wr || bus_wr;
    assign rd_en   = cw_rd;
    assign wr_addr = cw_wr ? ctrl_word[14:8] : bus_addr;
    assign wr_data = cw_wr ? ctrl_word[7:0]  : bus_wdata;

    assign sample_tick = (sync_pipe_r[2] == sync_pipe_r[1]) && sync_pipe_r[1] && !sync_last_r;

    // Flags a host write of a reserved code; the code is stored anyway
    always @*
    begin
        reserved_hit = 1'b0;
        if (wr_en)
        begin
            case (wr_addr)
                `OFS_FMT_CTRL:   reserved_hit = (wr_data[2:0] > `FMT_LJ24);
                `OFS_OVR_DEEMPH: reserved_hit = (wr_data[5:4] == 2'h3);
                `OFS_FSEL_LO:    reserved_hit = has_reserved_fsel(wr_data);
                `OFS_FSEL_HI:    reserved_hit = has_reserved_fsel(wr_data);
                default:         reserved_hit = 1'b0;
            endcase
        end
    end

    always @*
    begin
        irq_set = 8'h00;
        irq_set[`IRQ_ZERO_RISE]     = |(zero_det & ~zero_det_last_r);
        irq_set[`IRQ_ZERO_FALL]     = |(~zero_det & zero_det_last_r);
        irq_set[`IRQ_SOFT_RESET]    = soft_reset_pulse_pend_r;
        irq_set[`IRQ_RESERVED_CODE] = reserved_hit;
    end

    assign irq = |(irq_status_r & irq_mask_r);

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            sync_pipe_r     <= 3'h0;
            sync_last_r     <= 1'b0;
            zero_det_last_r <= 8'h00;
        end
        else if (ce)
        begin
            sync_pipe_r <= {sync_pipe_r[1:0], frame_sync_input};
            if (sync_pipe_r[2] == sync_pipe_r[1])
                sync_last_r <= sync_pipe_r[1];
            zero_det_last_r <= zero_det;
        end
    end

    // Zero run detection, held cleared in stream mode and during the soft reset pulse
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch = ch + 1)
        begin : g_zero
            zero_run_counter u_cnt
            (
                .clk_sys         (clk_sys),
                .rst             (rst),
                .ce              (ce),
                .clear           (one_bit_stream_mode || soft_reset_pulse),
                .sample_tick     (sample_tick),
                .sample_is_zero  (channel_sample_zero[ch]),
                .zero_detected_r (zero_det[ch])
            );
        end
    endgenerate

    // Register writes; soft reset restores the control fields, but a same-cycle write to an unlisted offset holds fmt_ctrl_r; other writes still land
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            fmt_ctrl_r    <= `FMT_CTRL_RESET;
            ovr_deemph_r  <= `OVR_DEEMPH_RESET;
            mode_ctrl_r   <= 7'h00;
            fsel_lo_r     <= `FSEL_RESET;
            fsel_hi_r     <= `FSEL_RESET;
            irq_mask_r    <= 4'h0;
            irq_status_r  <= 4'h0;
            soft_reset_pulse_pend_r   <= 1'b0;
        end
        else if (ce)
        begin
            soft_reset_pulse_pend_r <= 1'b0;
            if (soft_reset_pulse_pend_r)
            begin
                fmt_ctrl_r   <= `FMT_CTRL_RESET;
                ovr_deemph_r <= `OVR_DEEMPH_RESET;
                mode_ctrl_r  <= 7'h00;
                fsel_lo_r    <= `FSEL_RESET;
                fsel_hi_r    <= `FSEL_RESET;
            end
            if (wr_en)
            begin
                case (wr_addr)
                    `OFS_FMT_CTRL:   fmt_ctrl_r   <= wr_data;
                    `OFS_OVR_DEEMPH: ovr_deemph_r <= wr_data;
                    `OFS_MODE_CTRL:
                    begin
                        mode_ctrl_r <= wr_data[6:0];
                        // Bit is not stored, so no clearing write is needed
                        soft_reset_pulse_pend_r <= wr_data[`BIT_SOFT_RESET_PULSE];
                    end
                    `OFS_FSEL_LO:    fsel_lo_r    <= wr_data;
                    `OFS_FSEL_HI:    fsel_hi_r    <= wr_data;
                    `OFS_IRQ_MASK:   irq_mask_r   <= wr_data[3:0];
                    default:         fmt_ctrl_r   <= fmt_ctrl_r;
                endcase
            end
            // New events win over a write-one clear in the same cycle
            if (wr_en && wr_addr == `OFS_IRQ_STATUS)
                irq_status_r <= (irq_status_r & ~wr_data[3:0]) | irq_set[3:0];
            else
                irq_status_r <= irq_status_r | irq_set[3:0];
        end
    end

    // Field decode to the datapath
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            audio_format_sel          <= `FMT_RJ24;
            modulator_rate_sel        <= `OVR_X64;
            deemph_rate_sel           <= `DMF_44K1;
            pair_deemph_enable        <= 4'h0;
            one_bit_stream_mode       <= 1'b0;
            pair_phase_invert         <= 4'h0;
            channel_stream_filter_sel <= 16'h0000;
            soft_reset_pulse          <= 1'b0;
        end
        else if (ce)
        begin
            audio_format_sel   <= fmt_ctrl_r[`FLD_FMT_LSB +: 3];
            // Both upper codes mean the same rate, so fold them here
            modulator_rate_sel <= ovr_deemph_r[`FLD_OVR_LSB + 1] ? `OVR_X32
                                  : ovr_deemph_r[`FLD_OVR_LSB +: 2];
            deemph_rate_sel    <= ovr_deemph_r[`FLD_DMF_LSB +: 2];
            pair_deemph_enable <= ovr_deemph_r[`FLD_DM_LSB +: 4];
            one_bit_stream_mode <= mode_ctrl_r[`BIT_STREAM];
            pair_phase_invert  <= mode_ctrl_r[`FLD_DRV_LSB +: 4];
            channel_stream_filter_sel <= {fsel_hi_r, fsel_lo_r};
            soft_reset_pulse   <= soft_reset_pulse_pend_r;
        end
    end

    // Zero flag pins: combine then apply polarity
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            first_channel_zero_pin  <= 1'b0;
            second_channel_zero_pin <= 1'b0;
            upper_channels_zero_pin <= 1'b0;
        end
        else if (ce)
        begin
            if (mode_ctrl_r[`BIT_COMBINE])
            begin
                first_channel_zero_pin  <= (zero_det[0] & zero_det[1])
                                           ^ mode_ctrl_r[`BIT_POLARITY];
                second_channel_zero_pin <= mode_ctrl_r[`BIT_POLARITY];
            end
            else
            begin
                first_channel_zero_pin  <= (zero_det[0] | zero_det[1])
                                           ^ mode_ctrl_r[`BIT_POLARITY];
                second_channel_zero_pin <= (zero_det[0] | zero_det[1])
                                           ^ mode_ctrl_r[`BIT_POLARITY];
            end
            upper_channels_zero_pin <= (&zero_det[7:2])
                                       ^ mode_ctrl_r[`BIT_POLARITY];
        end
    end

    // Read answers one cycle after the strobe
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            bus_rdata_r   <= 8'h00;
            ctrl_rdata_r  <= 8'h00;
            ctrl_rvalid_r <= 1'b0;
        end
        else if (ce)
        begin
            bus_rdata_r   <= bus_rd ? read_reg(bus_addr) : 8'h00;
            ctrl_rvalid_r <= rd_en;
            ctrl_rdata_r  <= rd_en ? read_reg(ctrl_word[14:8]) : 8'h00;
        end
    end

endmodule
`default_nettype wire

// [hw/zero_run_counter.v]
// Per-channel run counter of consecutive all-zero samples
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_regs.vh"

module zero_run_counter
(
    // Clock and control
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       ce,
    input  wire       clear,
    // Sample stream
    input  wire       sample_tick,
    input  wire       sample_is_zero,
    // Result
    output reg        zero_detected_r
);

    reg [`ZERO_CNT_W-1:0] run_r;
    wire [`ZERO_CNT_W-1:0] run_limit;

    assign run_limit = `ZERO_RUN_SAMPLES;

    always @(posedge clk_sys)
    begin
        if (rst || clear)
        begin
            run_r           <= {`ZERO_CNT_W{1'b0}};
            zero_detected_r <= 1'b0;
        end
        else if (ce && sample_tick)
        begin
            if (!sample_is_zero)
            begin
                run_r           <= {`ZERO_CNT_W{1'b0}};
                zero_detected_r <= 1'b0;
            end
            else if (run_r != run_limit)
            begin
                run_r           <= run_r + {{(`ZERO_CNT_W-1){1'b0}}, 1'b1};
                // Declared on the sample that completes the run
                zero_detected_r <= (run_r == run_limit - {{(`ZERO_CNT_W-1){1'b0}}, 1'b1});
            end
        end
    end

endmodule
`default_nettype wire

// [pkg/dac_ctrl_regs.vh]
// Register offsets, field positions, reset values and timing counts of the control bank
`ifndef DAC_CTRL_REGS_VH
`define DAC_CTRL_REGS_VH

`define ADDR_W              7
`define OFS_FMT_CTRL        7'h0A
`define OFS_OVR_DEEMPH      7'h0B
`define OFS_MODE_CTRL       7'h0C
`define OFS_FSEL_LO         7'h0D
`define OFS_FSEL_HI         7'h0E
`define OFS_ZERO_STATUS     7'h10
`define OFS_CHAIN_ID        7'h11
`define OFS_IRQ_STATUS      7'h20
`define OFS_IRQ_MASK        7'h21

`define FMT_CTRL_RESET      8'h00
`define OVR_DEEMPH_RESET    8'h00
`define MODE_CTRL_RESET     8'h00
`define FSEL_RESET          8'h00

`define FLD_FMT_LSB         0
`define FLD_OVR_LSB         6
`define FLD_DMF_LSB         4
`define FLD_DM_LSB          0
`define BIT_SOFT_RESET_PULSE            7
`define BIT_STREAM          6
`define BIT_COMBINE         5
`define BIT_POLARITY        4
`define FLD_DRV_LSB         0

`define FMT_RJ24            3'h0
`define FMT_RJ20            3'h1
`define FMT_RJ18            3'h2
`define FMT_RJ16            3'h3
`define FMT_I2S24           3'h4
`define FMT_LJ24            3'h5
`define OVR_X64             2'h0
`define OVR_X128            2'h1
`define OVR_X32             2'h2
`define DMF_44K1            2'h0
`define DMF_48K             2'h1
`define DMF_32K             2'h2
`define FSEL_F1             2'h0
`define FSEL_F2             2'h1
`define FSEL_F3             2'h2

`define ZERO_RUN_SAMPLES    11'h400
`define ZERO_CNT_W          11

`define IRQ_ZERO_RISE       0
`define IRQ_ZERO_FALL       1
`define IRQ_SOFT_RESET      2
`define IRQ_RESERVED_CODE   3

`endif

// [testbench/dac_regs_checker.sv]
// Port-level assertions for the control register bank
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_regs.vh"
module dac_regs_checker
(
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               rst,
    // Requests
    input wire logic [15:0]        ctrl_word,
    input wire logic               ctrl_valid,
    input wire logic [`ADDR_W-1:0] bus_addr,
    input wire logic [7:0]         bus_wdata,
    input wire logic               bus_wr,
    input wire logic               bus_rd,
    input wire logic [4:0]         chain_identifier,
    // Answers
    input wire logic               ctrl_rvalid_r,
    input wire logic [7:0]         bus_rdata_r,
    input wire logic [2:0]         audio_format_sel,
    input wire logic [1:0]         modulator_rate_sel,
    input wire logic               one_bit_stream_mode,
    input wire logic               soft_reset_pulse,
    input wire logic               first_channel_zero_pin,
    input wire logic               second_channel_zero_pin
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] wd1_r;
    logic [7:0] wd2_r;
    logic [7:0] mode_r;
    logic       rw_r;
    wire        ctrl_mode_wr = ctrl_valid && !ctrl_word[15] && ctrl_word[14:8] == `OFS_MODE_CTRL;
    wire        bus_mode_wr = bus_wr && bus_addr == `OFS_MODE_CTRL;
    // Shadow of the mode register so pin relations can be judged from ports alone
    always_ff @(posedge clk_sys)
    begin
        wd1_r <= bus_wdata;
        wd2_r <= wd1_r;
        rw_r  <= ctrl_word[15];
        if (rst || soft_reset_pulse)
            mode_r <= 8'h00;
        else if (ctrl_mode_wr)
            mode_r <= ctrl_word[7:0];
        else if (bus_mode_wr)
            mode_r <= bus_wdata;
    end
    AST_RD_IDLE: assert property (!$past(bus_rd) |-> bus_rdata_r == 8'h00)
        else $error("read data not idle");
    AST_ID_READ: assert property ($past(bus_rd) && $past(bus_addr) == `OFS_CHAIN_ID
        |-> bus_rdata_r == {3'h0, $past(chain_identifier)}) else $error("bad identifier read");
    AST_SOFT_RESET_PULSE_ONE: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("reset pulse too long");
    AST_SOFT_RESET_PULSE_CAUSE: assert property (bus_mode_wr && bus_wdata[7] |-> ##2 soft_reset_pulse)
        else $error("no reset pulse");
    AST_FMT_OUT: assert property (bus_wr && bus_addr == `OFS_FMT_CTRL
        |-> ##2 audio_format_sel == wd2_r[2:0]) else $error("format output wrong");
    AST_OVR_OUT: assert property (bus_wr && bus_addr == `OFS_OVR_DEEMPH
        |-> ##2 modulator_rate_sel == (wd2_r[7] ? 2'h2 : wd2_r[7:6])) else $error("rate wrong");
    AST_STREAM_NO_ZERO: assert property (bus_rd && bus_addr == `OFS_ZERO_STATUS
        && one_bit_stream_mode && $past(one_bit_stream_mode) |=> bus_rdata_r == 8'h00)
        else $error("zero status in stream mode");
    AST_UNCOMB: assert property (!mode_r[5] && mode_r == $past(mode_r, 4)
        |-> first_channel_zero_pin == second_channel_zero_pin) else $error("pins differ");
    AST_COMB_IDLE: assert property (mode_r[5] && mode_r == $past(mode_r, 4)
        |-> second_channel_zero_pin == mode_r[4]) else $error("second pin not idle");
    AST_CTRL_ANSWER: assert property (ctrl_valid |=> ctrl_rvalid_r == rw_r)
        else $error("control answer wrong");
endmodule
bind audio_dac_control_registers dac_regs_checker u_chk (.clk_sys(clk_sys), .rst(rst),
    .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .chain_identifier(chain_identifier), .ctrl_rvalid_r(ctrl_rvalid_r),
    .bus_rdata_r(bus_rdata_r), .audio_format_sel(audio_format_sel),
    .modulator_rate_sel(modulator_rate_sel), .one_bit_stream_mode(one_bit_stream_mode),
    .soft_reset_pulse(soft_reset_pulse), .first_channel_zero_pin(first_channel_zero_pin),
    .second_channel_zero_pin(second_channel_zero_pin));
`default_nettype wire

// [testbench/host_ctrl_model.sv]
// Host controller model sending control words to the register bank
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model
(
    // Clock
    input  wire logic        clk_sys,
    // Control word port
    output var  logic [15:0] ctrl_word,
    output var  logic        ctrl_valid,
    input  wire logic [7:0]  ctrl_rdata_r,
    input  wire logic        ctrl_rvalid_r
);
    initial
    begin
        ctrl_word = 16'h0000;
        ctrl_valid = 1'b0;
    end
    // Callers pass only defined field codes
    task automatic send(input logic rd, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        ctrl_word <= {rd, a, d};
        ctrl_valid <= 1'b1;
        @(posedge clk_sys);
        ctrl_valid <= 1'b0;
        // Released word turns to garbage so a late sample cannot match by luck
        ctrl_word <= ~{rd, a, d};
    endtask
    task automatic read_word(input logic [6:0] a, output logic [7:0] d, output logic v);
        send(1'b1, a, 8'h00);
        #1;
        v = ctrl_rvalid_r;
        d = ctrl_rdata_r;
    endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_regs.vh"
module testbench;
    logic               clk_sys, rst, ce, bus_wr, bus_rd, frame_sync_input, v;
    logic [`ADDR_W-1:0] bus_addr;
    logic [7:0]         bus_wdata, bus_rdata_r, ctrl_rdata_r, d, channel_sample_zero;
    logic               ctrl_valid, ctrl_rvalid_r, one_bit_stream_mode, soft_reset_pulse, irq;
    logic [15:0]        ctrl_word, channel_stream_filter_sel;
    logic [4:0]         chain_identifier;
    logic [2:0]         audio_format_sel;
    logic [1:0]         modulator_rate_sel, deemph_rate_sel;
    logic [3:0]         pair_deemph_enable, pair_phase_invert;
    logic               first_channel_zero_pin, second_channel_zero_pin, upper_channels_zero_pin;
    int                 n_mismatch, tests_run, cycles, n;
    audio_dac_control_registers DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid), .ctrl_rdata_r(ctrl_rdata_r),
        .ctrl_rvalid_r(ctrl_rvalid_r), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r),
        .frame_sync_input(frame_sync_input), .channel_sample_zero(channel_sample_zero),
        .chain_identifier(chain_identifier), .audio_format_sel(audio_format_sel),
        .modulator_rate_sel(modulator_rate_sel), .deemph_rate_sel(deemph_rate_sel),
        .pair_deemph_enable(pair_deemph_enable), .one_bit_stream_mode(one_bit_stream_mode),
        .pair_phase_invert(pair_phase_invert), .soft_reset_pulse(soft_reset_pulse),
        .channel_stream_filter_sel(channel_stream_filter_sel),
        .first_channel_zero_pin(first_channel_zero_pin),
        .second_channel_zero_pin(second_channel_zero_pin),
        .upper_channels_zero_pin(upper_channels_zero_pin), .irq(irq));
    host_ctrl_model host (.clk_sys(clk_sys), .ctrl_word(ctrl_word), .ctrl_valid(ctrl_valid),
        .ctrl_rdata_r(ctrl_rdata_r), .ctrl_rvalid_r(ctrl_rvalid_r));
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Ceiling well above the roughly 4300 cycles the sequence needs
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            n_mismatch++;
            complete_run;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pause(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] dat);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= dat;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 check(16'(bus_rdata_r), 16'(exp));
    endtask
    // Four clock cycles per sample period; trailing wait covers sync and flag latency
    task automatic samples(input int k);
        repeat (k)
        begin
            @(posedge clk_sys);
            frame_sync_input <= 1'b1;
            repeat (2) @(posedge clk_sys);
            frame_sync_input <= 1'b0;
            @(posedge clk_sys);
        end
        pause(8);
    endtask
    task automatic pins(input logic [2:0] exp);
        check(16'({first_channel_zero_pin, second_channel_zero_pin, upper_channels_zero_pin}),
            16'(exp));
    endtask
    initial
    begin
        {rst, ce, bus_wr, bus_rd, frame_sync_input} = 5'h18;
        {bus_addr, bus_wdata, channel_sample_zero, chain_identifier} = 0;
        {n_mismatch, tests_run, cycles} = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            rdc(7'(`OFS_FMT_CTRL + i), 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            wr(`OFS_FMT_CTRL, 8'(i));
            pause(1);
            check(16'(audio_format_sel), 16'(i));
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(`OFS_OVR_DEEMPH, {2'(i), 2'(i % 3), 4'h1 << i});
            pause(1);
            check({modulator_rate_sel, deemph_rate_sel, pair_deemph_enable},
                {(i > 1) ? 2'h2 : 2'(i), 2'(i % 3), 4'h1 << i});
        end
        wr(`OFS_MODE_CTRL, 8'h4A);
        pause(1);
        check(16'({one_bit_stream_mode, pair_phase_invert}), 16'h001A);
        wr(`OFS_FSEL_LO, 8'h24);
        wr(`OFS_FSEL_HI, 8'h89);
        pause(1);
        check(channel_stream_filter_sel, 16'h8924);
        $display("control fields done");
        host.read_word(`OFS_FSEL_LO, d, v);
        check(16'({v, d}), 16'h0124);
        host.send(1'b0, `OFS_FMT_CTRL, 8'h03);
        rdc(`OFS_FMT_CTRL, 8'h03);
        wr(7'h05, 8'hFF);
        rdc(7'h05, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_sys);
            chain_identifier <= i ? 5'h1F : 5'h0A;
            rdc(`OFS_CHAIN_ID, i ? 8'h1F : 8'h0A);
        end
        wr(`OFS_MODE_CTRL, 8'h80);
        n = 0;
        repeat (4)
        begin
            pause(1);
            if (soft_reset_pulse === 1'b1)
                n++;
        end
        check(16'(n), 16'h0001);
        rdc(`OFS_FMT_CTRL, 8'h00);
        rdc(`OFS_FSEL_HI, 8'h00);
        rdc(`OFS_IRQ_STATUS, 8'h04);
        // A write while the clock enable is low must be lost
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(`OFS_FSEL_LO, 8'h11);
        ce <= 1'b1;
        rdc(`OFS_FSEL_LO, 8'h00);
        $display("access and soft reset done");
        wr(`OFS_IRQ_STATUS, 8'hFF);
        channel_sample_zero <= 8'hFF;
        samples(1023);
        rdc(`OFS_ZERO_STATUS, 8'h00);
        pins(3'h0);
        samples(1);
        rdc(`OFS_ZERO_STATUS, 8'hFF);
        pins(3'h7);
        check(16'(irq), 16'h0000);
        wr(`OFS_IRQ_MASK, 8'h01);
        pause(1);
        check(16'(irq), 16'h0001);
        wr(`OFS_IRQ_STATUS, 8'h01);
        pause(1);
        check(16'(irq), 16'h0000);
        @(posedge clk_sys);
        channel_sample_zero <= 8'hFE;
        samples(1);
        rdc(`OFS_ZERO_STATUS, 8'hFE);
        rdc(`OFS_IRQ_STATUS, 8'h02);
        pins(3'h7);
        wr(`OFS_MODE_CTRL, 8'h20);
        pause(3);
        pins(3'h1);
        wr(`OFS_MODE_CTRL, 8'h30);
        pause(3);
        pins(3'h6);
        @(posedge clk_sys);
        channel_sample_zero <= 8'hEE;
        samples(1);
        rdc(`OFS_ZERO_STATUS, 8'hEE);
        pins(3'h7);
        wr(`OFS_MODE_CTRL, 8'h40);
        pause(3);
        rdc(`OFS_ZERO_STATUS, 8'h00);
        $display("zero detection done");
        complete_run;
    end
endmodule
`default_nettype wire
